// ---- rtl/fbl_loop_ctrl.sv ----
// Purpose: feedback assignment and closed loop activation control
// Assumes: apb slave, sensor events synchronous to core_clk
// Notes: masks per sensor, sensor 1 always sensorless
// Notes on behaviour
// - mask bit 0 position, bit 1 velocity, bit 2 commutation.
// - first mask entry is sensorless; later entries follow sensor order.
// - per controller, first sensor from 2 upward with bit set wins.
// - two commutation sensors: use whichever currently has alignment.
// - no aligned commutation sensor: open loop alignment regardless of bit 4; the code needs bit 4 when no sensor has the commutation bit.
// - closed loop needs submode bit 0; auto setup success sets it.
// - absolute aligned commutation sensor: closed loop at switch-on.
// - encoder commutation: open loop until index passed once.
// - bit 4: one alignment per restart at first enable, then enabled.
// - statusword bit 15 shows closed loop while operation enabled.
// - slow speed needs closed loop and submode bit 7.
// - slow/closed changeover at encoder-derived speed with 10% hysteresis.
// - at standstill run closed loop even with slow speed enabled.
// - slow speed: constant current, following error may engage vector control.
// - speed is position delta per cycle, low-pass filtered.
// - slow speed only with an encoder among feedback sensors.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "fbl_defines.svh"
module fbl_loop_ctrl import fbl_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic enc_index,
   input wire logic [15:0] enc_count,
   input wire logic autosetup_done,
   input wire logic op_enable_req,
   input wire logic op_enabled,
   input wire logic follow_err,
   output logic [1:0] pos_sensor,
   output logic [1:0] vel_sensor,
   output logic [1:0] com_sensor,
   output logic closed_loop,
   output logic slow_speed,
   output logic vector_ctrl,
   output logic aligning,
   output logic enter_op_ok,
   output logic status_cl
);
   logic [7:0] mask_q [`FBL_NSENS];
   logic [7:0] submode;
   logic [7:0] kind_q;
   logic index_seen;
   logic align_done;
   logic [9:0] align_cnt;
   fbl_loop_t state;
   fbl_loop_t next_state;
   logic [`FBL_NSENS*8-1:0] mask_flat;
   logic pos_f, vel_f, com_f;
   logic [1:0] pos_i, vel_i, com_i;
   logic [15:0] speed_abs;

   // apb decode
   wire setup = psel && !penable;
   wire access = psel && penable;
   wire wr = access && pwrite;
   wire hit_mask0 = paddr == `FBL_OFF_MASK0;
   wire hit_mask1 = paddr == `FBL_OFF_MASK1;
   wire hit_mask2 = paddr == `FBL_OFF_MASK2;
   wire hit_sub = paddr == `FBL_OFF_SUBMODE;
   wire hit_stat = paddr == `FBL_OFF_STATUS;
   wire hit_speed = paddr == `FBL_OFF_SPEED;
   wire hit_ctrl = paddr == `FBL_OFF_CTRL;
   wire hit_kind = paddr == `FBL_OFF_KIND;
   wire mapped = hit_mask0 | hit_mask1 | hit_mask2 | hit_sub | hit_stat | hit_speed
      | hit_ctrl | hit_kind;

   genvar g;
   generate
      for (g = 0; g < `FBL_NSENS; g++) begin : g_flat
         assign mask_flat[g*8 +: 8] = mask_q[g];
      end
   endgenerate

   fbl_select u_pos (.masks(mask_flat), .bit_sel(2'(`FBL_BIT_POS)), .found(pos_f),
      .idx(pos_i));
   fbl_select u_vel (.masks(mask_flat), .bit_sel(2'(`FBL_BIT_VEL)), .found(vel_f),
      .idx(vel_i));
   fbl_select u_com (.masks(mask_flat), .bit_sel(2'(`FBL_BIT_COM)), .found(com_f),
      .idx(com_i));
   fbl_speed u_speed (.core_clk(core_clk), .rst_n(rst_n), .enc_count(enc_count),
      .speed_abs(speed_abs));

   // kind of sensor 2 in bits 1:0, sensor 3 in bits 3:2; sensor 1 is sensorless
   wire [1:0] kind2 = kind_q[1:0];
   wire [1:0] kind3 = kind_q[3:2];
   wire com2 = mask_q[1][`FBL_BIT_COM];
   wire com3 = mask_q[2][`FBL_BIT_COM];
   wire hall2 = com2 && kind2 == FBL_HALL;
   wire hall3 = com3 && kind3 == FBL_HALL;
   wire enc2 = com2 && kind2 == FBL_ENCODER;
   wire enc3 = com3 && kind3 == FBL_ENCODER;
   // hall always aligned, encoder only after index; best sensor wins
   wire enc_aligned = (enc2 || enc3) && index_seen;
   wire hall_aligned = hall2 || hall3;
   wire have_align = enc_aligned || hall_aligned || align_done;
   wire [1:0] best_com = enc_aligned ? (enc2 ? 2'h1 : 2'h2)
      : (hall2 ? 2'h1 : (hall3 ? 2'h2 : com_i));
   wire enc_present = kind2 == FBL_ENCODER || kind3 == FBL_ENCODER;
   wire cl_enable = submode[`FBL_SUB_CL];
   // alignment forced when a commutation sensor lacks alignment, independent of bit 4; with no commutation sensor only bit 4 forces it
   wire need_align = cl_enable && !have_align && (com_f || submode[`FBL_SUB_ALIGN]);
   wire slow_ok = submode[`FBL_SUB_SLOW] && enc_present;
   // threshold constant from encoder resolution
   wire above_up = speed_abs > 16'(`FBL_SLOW_UP);
   wire below_dn = speed_abs < 16'(`FBL_SLOW_DN);
   wire standstill = speed_abs == 16'h0000;
   wire align_end = align_cnt == 10'(`FBL_ALIGN_CLK - 1);
   // ctrl register write of bit 0 clears alignment knowledge (restart)
   wire restart = wr && hit_ctrl && pwdata[0];

   always_comb begin
      next_state = state;
      unique case (state)
         FBL_OPEN: begin
            if (need_align && op_enable_req) begin
               next_state = FBL_ALIGNING;
            end else if (cl_enable && have_align) begin
               next_state = FBL_CLOSED;
            end
         end
         FBL_ALIGNING: begin
            if (align_end) begin
               next_state = FBL_CLOSED;
            end
         end
         FBL_CLOSED: begin
            if (!cl_enable) begin
               next_state = FBL_OPEN;
            end else if (slow_ok && below_dn && !standstill) begin
               next_state = FBL_SLOW;
            end
         end
         FBL_SLOW: begin
            if (!cl_enable) begin
               next_state = FBL_OPEN;
            end else if (!slow_ok || above_up || standstill) begin
               next_state = FBL_CLOSED;
            end
         end
      endcase
      // restart folded in here so outputs never lag the state by a cycle
      if (restart) begin
         next_state = FBL_OPEN;
      end
   end

   wire loop_on = next_state == FBL_CLOSED || next_state == FBL_SLOW;

   wire [31:0] rd_status = {16'h0000, status_cl, 10'h000, slow_speed, aligning,
      index_seen, align_done, closed_loop};
   wire [31:0] rd_data = hit_mask0 ? {24'h000000, mask_q[0]}
      : hit_mask1 ? {24'h000000, mask_q[1]}
      : hit_mask2 ? {24'h000000, mask_q[2]}
      : hit_sub ? {24'h000000, submode}
      : hit_stat ? rd_status
      : hit_speed ? {16'h0000, speed_abs}
      : hit_kind ? {24'h000000, kind_q}
      : 32'h00000000;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q[0] <= `FBL_RST_MASK0;
         mask_q[1] <= `FBL_RST_MASK1;
         mask_q[2] <= `FBL_RST_MASK2;
         submode <= `FBL_RST_SUBMODE;
         kind_q <= `FBL_RST_KIND;
      end else begin
         if (wr && hit_mask0) mask_q[0] <= pwdata[7:0];
         if (wr && hit_mask1) mask_q[1] <= pwdata[7:0];
         if (wr && hit_mask2) mask_q[2] <= pwdata[7:0];
         if (wr && hit_kind) kind_q <= pwdata[7:0];
         if (autosetup_done) begin
            submode <= (wr && hit_sub ? pwdata[7:0] : submode)
               | 8'(1 << `FBL_SUB_CL);
         end else if (wr && hit_sub) begin
            submode <= pwdata[7:0];
         end
      end
   end

   // zero wait state answer, pready registered from the setup phase, no bus stalling
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup;
         pslverr <= setup && !mapped;
         prdata <= (setup && !pwrite) ? rd_data : 32'h00000000;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         index_seen <= 1'b0;
         align_done <= 1'b0;
         align_cnt <= 10'h000;
         state <= FBL_OPEN;
      end else begin
         // index event wins over a simultaneous restart
         if (enc_index) begin
            index_seen <= 1'b1;
         end else if (restart) begin
            index_seen <= 1'b0;
         end
         if (state == FBL_ALIGNING && align_end) begin
            align_done <= 1'b1;
         end else if (restart) begin
            align_done <= 1'b0;
         end
         align_cnt <= (state == FBL_ALIGNING) ? align_cnt + 10'h001 : 10'h000;
         state <= next_state;
      end
   end

   // brake must already be off before op_enable_req; not checked here
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pos_sensor <= 2'h0;
         vel_sensor <= 2'h0;
         com_sensor <= 2'h0;
         closed_loop <= 1'b0;
         slow_speed <= 1'b0;
         vector_ctrl <= 1'b0;
         aligning <= 1'b0;
         enter_op_ok <= 1'b0;
         status_cl <= 1'b0;
      end else begin
         pos_sensor <= pos_f ? pos_i : 2'h0;
         vel_sensor <= vel_f ? vel_i : 2'h0;
         com_sensor <= best_com;
         closed_loop <= loop_on;
         slow_speed <= next_state == FBL_SLOW;
         // constant current in slow speed; vector control on following error
         vector_ctrl <= next_state == FBL_CLOSED || (next_state == FBL_SLOW && follow_err);
         aligning <= next_state == FBL_ALIGNING;
         // enable held back while aligning
         enter_op_ok <= op_enable_req && next_state != FBL_ALIGNING && !need_align;
         status_cl <= op_enabled && loop_on;
      end
   end
endmodule // fbl_loop_ctrl

// ---- rtl/fbl_defines.svh ----
// Purpose: constants for feedback assignment and loop activation
// Assumes: apb word registers, 50 MHz core clock
// Notes: offsets are byte addresses
`ifndef FBL_DEFINES_SVH
`define FBL_DEFINES_SVH
`define FBL_NSENS 3
`define FBL_OFF_MASK0 12'h000
`define FBL_OFF_MASK1 12'h004
`define FBL_OFF_MASK2 12'h008
`define FBL_OFF_SUBMODE 12'h00C
`define FBL_OFF_STATUS 12'h010
`define FBL_OFF_SPEED 12'h014
`define FBL_OFF_CTRL 12'h018
`define FBL_OFF_KIND 12'h01C
`define FBL_BIT_POS 0
`define FBL_BIT_VEL 1
`define FBL_BIT_COM 2
`define FBL_SUB_CL 0
`define FBL_SUB_ALIGN 4
`define FBL_SUB_SLOW 7
`define FBL_SW_CL 15
`define FBL_RST_MASK0 8'h00
`define FBL_RST_MASK1 8'h06
`define FBL_RST_MASK2 8'h05
`define FBL_RST_SUBMODE 8'h00
`define FBL_RST_KIND 8'h09
`define FBL_CYCLE_US 50
`define FBL_CYCLE_CLK ((`FBL_CYCLE_US * 50) / 1)
`define FBL_ENC_RES 2000
`define FBL_SLOW_UP (32'd600000 / `FBL_ENC_RES)
`define FBL_SLOW_DN ((`FBL_SLOW_UP * 9) / 10)
`define FBL_ALIGN_US 20
`define FBL_ALIGN_CLK (`FBL_ALIGN_US * 50)
`endif

// ---- rtl/fbl_pkg.sv ----
// Purpose: types for feedback assignment and loop activation
// Assumes: nothing
// Notes: sensor kinds as configured by software
package fbl_pkg;
   typedef enum logic [1:0] {FBL_NONE, FBL_HALL, FBL_ENCODER} fbl_kind_t;
   typedef enum {FBL_OPEN, FBL_ALIGNING, FBL_CLOSED, FBL_SLOW} fbl_loop_t;
endpackage

// ---- rtl/fbl_select.sv ----
// Purpose: pick the first sensor from 2 upward whose mask bit is set
// Assumes: masks packed per sensor, sensor 1 sensorless
// Notes: combinational search
`timescale 1ns/1ns
`include "fbl_defines.svh"
module fbl_select import fbl_pkg::*; (
   input wire logic [`FBL_NSENS*8-1:0] masks,
   input wire logic [1:0] bit_sel,
   output logic found,
   output logic [1:0] idx
);
   always_comb begin
      found = 1'b0;
      idx = 2'h0;
      for (int i = 1; i < `FBL_NSENS; i++) begin
         if (!found && masks[i*8 + bit_sel]) begin
            found = 1'b1;
            idx = 2'(i);
         end
      end
   end
endmodule // fbl_select

// ---- rtl/fbl_speed.sv ----
// Purpose: speed from position change per fixed cycle, low-pass filtered
// Assumes: encoder count is a free running counter
// Notes: filter is a 1/8 iir, output in encoder counts per cycle
`timescale 1ns/1ns
`include "fbl_defines.svh"
module fbl_speed import fbl_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [15:0] enc_count,
   output logic [15:0] speed_abs
);
   logic [12:0] cyc;
   logic [15:0] last;
   logic [18:0] filt;
   wire tick = (cyc == 13'(`FBL_CYCLE_CLK - 1));
   wire [15:0] delta = enc_count - last;
   wire [15:0] mag = delta[15] ? 16'(-delta) : delta;
   // delta per fixed cycle, then filter, avoids peaks at low speed
   wire [18:0] next_filt = filt - 19'(filt >> 3) + 19'(mag);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc <= 13'h0000;
         last <= 16'h0000;
         filt <= 19'h00000;
         speed_abs <= 16'h0000;
      end else begin
         cyc <= tick ? 13'h0000 : cyc + 13'h0001;
         if (tick) begin
            last <= enc_count;
            filt <= next_filt;
            speed_abs <= 16'(next_filt >> 3);
         end
      end
   end
endmodule // fbl_speed

// ---- tb/fbl_loop_ctrl_checker.sv ----
// Purpose: port checks for loop activation
// Assumes: one clock domain
// Notes: alignment span counted in helper logic
`timescale 1ns/1ns
`include "fbl_defines.svh"
module fbl_loop_ctrl_checker (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic op_enable_req,
   input wire logic op_enabled,
   input wire logic follow_err,
   input wire logic closed_loop,
   input wire logic slow_speed,
   input wire logic vector_ctrl,
   input wire logic aligning,
   input wire logic enter_op_ok,
   input wire logic status_cl
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // cycles spent aligning, too long for a repetition count
   logic [10:0] align_len;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         align_len <= 11'h000;
      end else begin
         align_len <= aligning ? align_len + 11'h001 : 11'h000;
      end
   end
   chk_slow_needs_cl: assert property (slow_speed |-> closed_loop)
      else $error("slow speed without closed loop");
   chk_status_on: assert property ($past(op_enabled) |-> status_cl == closed_loop)
      else $error("status bit missing");
   chk_status_off: assert property (!closed_loop [*2] |-> !status_cl)
      else $error("status bit without loop");
   chk_align_holds_op: assert property (aligning |-> !enter_op_ok)
      else $error("enable granted while aligning");
   chk_align_span: assert property ($fell(aligning) |-> align_len == 11'(`FBL_ALIGN_CLK))
      else $error("alignment span wrong");
   chk_align_then_op: assert property ($fell(aligning) && op_enable_req |-> ##[0:2] enter_op_ok)
      else $error("enable not granted after alignment");
   chk_vector_on_err: assert property (slow_speed && follow_err |=> ##[0:2] vector_ctrl)
      else $error("vector control not engaged");
   chk_ready_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule // fbl_loop_ctrl_checker
bind fbl_loop_ctrl fbl_loop_ctrl_checker chk_u (.core_clk, .rst_n, .psel, .penable, .pready,
   .pslverr, .op_enable_req, .op_enabled, .follow_err, .closed_loop, .slow_speed,
   .vector_ctrl, .aligning, .enter_op_ok, .status_cl);

// ---- tb/fbl_sensor_model.sv ----
// Purpose: encoder and motor stand-in
// Assumes: counts move by step each cycle
// Notes: index is a one cycle pulse on command
`timescale 1ns/1ns
module fbl_sensor_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic index_cmd,
   input wire logic [3:0] step,
   output logic enc_index,
   output logic [15:0] enc_count
);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         enc_count <= 16'h0000;
         enc_index <= 1'b0;
      end else begin
         enc_count <= enc_count + {12'h000, step};
         enc_index <= index_cmd;
      end
   end
endmodule // fbl_sensor_model

// ---- tb/tb_feedback_assign_loop_activation.sv ----
// Purpose: self-checking bench for loop activation
// Assumes: one access cycle per apb transfer
// Notes: slow speed reached by a short encoder burst
`timescale 1ns/1ns
`include "fbl_defines.svh"
module tb_feedback_assign_loop_activation;
   logic core_clk, rst_n, psel, penable, pwrite, autosetup_done, op_enable_req;
   logic op_enabled, follow_err, index_cmd, pready, pslverr, err, enc_index;
   logic closed_loop, slow_speed, vector_ctrl, aligning, enter_op_ok, status_cl;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] enc_count;
   logic [1:0] pos_sensor, vel_sensor, com_sensor;
   logic [3:0] step;
   int fail_count, checks;
   fbl_loop_ctrl dut_u (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .enc_index, .enc_count, .autosetup_done, .op_enable_req,
      .op_enabled, .follow_err, .pos_sensor, .vel_sensor, .com_sensor, .closed_loop,
      .slow_speed, .vector_ctrl, .aligning, .enter_op_ok, .status_cl);
   fbl_sensor_model sensor_u (.core_clk, .rst_n, .index_cmd, .step, .enc_index, .enc_count);
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic print_verdict;
      if (fail_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // waits on pready, the watchdog ends a hang
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic t_reset;
      logic [7:0] rv [4];
      rv = '{`FBL_RST_MASK0, `FBL_RST_MASK1, `FBL_RST_MASK2, `FBL_RST_SUBMODE};
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0);
         chk("reset value", {24'h0, rv[i]}, rd);
      end
      chk("reset pick", 32'h25, {26'h0, pos_sensor, vel_sensor, com_sensor});
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
   endtask
   task automatic t_search;
      logic [7:0] m2 [5];
      logic [7:0] m3 [5];
      logic [5:0] ex [5];
      m2 = '{8'h07, 8'h00, 8'h00, 8'h01, 8'h04};
      m3 = '{8'h07, 8'h07, 8'h00, 8'h06, 8'h03};
      ex = '{6'h15, 6'h2A, 6'h00, 6'h1A, 6'h29};
      apb(1'b1, `FBL_OFF_MASK0, 32'h07); // sensorless is never searched
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, `FBL_OFF_MASK1, {24'h0, m2[i]});
         apb(1'b1, `FBL_OFF_MASK2, {24'h0, m3[i]});
         cyc(2);
         chk("pick", {26'h0, ex[i]}, {26'h0, pos_sensor, vel_sensor, com_sensor});
      end
      apb(1'b1, `FBL_OFF_MASK0, 32'h00);
      apb(1'b1, `FBL_OFF_MASK1, 32'h06);
      apb(1'b1, `FBL_OFF_MASK2, 32'h05);
   endtask
   task automatic t_loop;
      cyc(2);
      chk("loop before setup", 32'h0, {31'h0, closed_loop});
      autosetup_done <= 1'b1;
      @(posedge core_clk) autosetup_done <= 1'b0;
      cyc(3);
      apb(1'b0, `FBL_OFF_SUBMODE, 32'h0);
      chk("setup bit", 32'h1, {31'h0, rd[0]});
      chk("loop with hall", 32'h1, {31'h0, closed_loop});
      op_enabled <= 1'b1;
      cyc(3);
      apb(1'b0, `FBL_OFF_STATUS, 32'h0);
      chk("status bit", 32'h1, {31'h0, rd[15]});
      op_enabled <= 1'b0;
      apb(1'b1, `FBL_OFF_MASK1, 32'h02); // encoder alone commutates
      apb(1'b1, `FBL_OFF_CTRL, 32'h1); // restart counts as switch-on
      cyc(3);
      chk("loop before index", 32'h0, {31'h0, closed_loop});
      chk("status off", 32'h0, {31'h0, status_cl});
      index_cmd <= 1'b1;
      @(posedge core_clk) index_cmd <= 1'b0;
      cyc(4);
      chk("loop after index", 32'h1, {31'h0, closed_loop});
      apb(1'b1, `FBL_OFF_MASK1, 32'h06);
      cyc(2);
      chk("best commutation", 32'h2, {30'h0, com_sensor});
      apb(1'b1, `FBL_OFF_MASK1, 32'h02);
      apb(1'b1, `FBL_OFF_SUBMODE, 32'h81);
      cyc(20);
      chk("slow at standstill", 32'h0, {31'h0, slow_speed});
   endtask
   // short burst leaves a small nonzero speed, below the changeover
   task automatic t_slow;
      step <= 4'h1;
      cyc(1000);
      step <= 4'h0;
      cyc(5100);
      chk("slow below changeover", 32'h1, {31'h0, slow_speed});
      chk("loop in slow", 32'h1, {31'h0, closed_loop});
      follow_err <= 1'b1;
      cyc(3);
      chk("vector on error", 32'h1, {31'h0, vector_ctrl});
      follow_err <= 1'b0;
      cyc(3);
      chk("constant current", 32'h0, {31'h0, vector_ctrl});
      apb(1'b1, `FBL_OFF_KIND, 32'h05);
      cyc(3);
      chk("slow needs encoder", 32'h0, {31'h0, slow_speed});
      apb(1'b1, `FBL_OFF_KIND, 32'h09);
      step <= 4'h1;
      cyc(5100);
      chk("slow left above", 32'h0, {31'h0, slow_speed});
      step <= 4'h0;
   endtask
   task automatic t_align;
      apb(1'b1, `FBL_OFF_CTRL, 32'h1); // restart forgets the index
      apb(1'b1, `FBL_OFF_SUBMODE, 32'h11); // no brake in this bench
      op_enable_req <= 1'b1;
      cyc(3);
      chk("aligning", 32'h1, {31'h0, aligning});
      chk("enable held", 32'h0, {31'h0, enter_op_ok});
      while (aligning === 1'b1) @(posedge core_clk);
      cyc(2);
      chk("enable after", 32'h1, {31'h0, enter_op_ok});
      op_enable_req <= 1'b0;
      cyc(3);
      op_enable_req <= 1'b1;
      cyc(3);
      chk("one alignment", 32'h0, {31'h0, aligning});
   endtask
   initial begin
      {rst_n, psel, penable, pwrite, autosetup_done, op_enable_req} = 6'h00;
      {op_enabled, follow_err, index_cmd, paddr, pwdata, step} = '0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      step <= 4'h0;
      t_reset;
      t_search;
      t_loop;
      t_slow;
      t_align;
      print_verdict;
   end
   initial begin
      #600000;
      fail_count++;
      print_verdict;
   end
endmodule // tb_feedback_assign_loop_activation
